/* hw/fpr_pkg.sv */
package fpr_pkg;
    // clock rate
    localparam int CLK_MHZ = 200;
    // register byte offsets
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // config field positions
    localparam int RATE_LSB = 0;
    localparam int RAMP_EN_BIT = 3;
    localparam int TACH_SYNC_BIT = 4;
    localparam int MIN_OUT1_BIT = 5;
    localparam int MIN_OUT2_BIT = 6;
    localparam int MIN_OUT3_BIT = 7;
    // config reset value: ramp off, slowest rate, off below threshold
    localparam logic [7:0] CFG_RESET = 8'h00;
    // status field positions
    localparam int STAT_BUSY_BIT = 8;
    // a full 33%..100% ramp at code 000 spans 171 duty steps in 35 s
    localparam int RAMP_FULL_TIME_MS = 35000;
    localparam int RAMP_SPAN_STEPS = 171;
    localparam int SLOT_TIME_US = (RAMP_FULL_TIME_MS * 1000) / RAMP_SPAN_STEPS;
    localparam int SLOT_CYCLES = SLOT_TIME_US * CLK_MHZ;

    // duty increase per time slot for each rate code
    function automatic logic [7:0] fpr_step_size(input logic [2:0] rate);
        case (rate)
            3'h0: fpr_step_size = 8'h01;
            3'h1: fpr_step_size = 8'h02;
            3'h2: fpr_step_size = 8'h03;
            3'h3: fpr_step_size = 8'h05;
            3'h4: fpr_step_size = 8'h08;
            3'h5: fpr_step_size = 8'h0C;
            3'h6: fpr_step_size = 8'h18;
            default: fpr_step_size = 8'h30;
        endcase
    endfunction : fpr_step_size

    // ramp engine states
    typedef enum logic [0:0] {
        RAMP_HOLD = 1'b0,
        RAMP_MOVE = 1'b1
    } fpr_ramp_state_type;
endpackage : fpr_pkg

/* hw/fpr_ramp.sv */
`timescale 1ns/1ps
// duty ramp engine for fan drive output 1
module fpr_ramp
    import fpr_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_b,
    fpr_ramp_if.engine rif
);
    fpr_ramp_state_type state, next_state; // moving or settled
    logic [31:0] slotCount, next_slotCount; // cycles into current slot
    logic [7:0] duty, next_duty; // applied duty
    logic slotTick; // last cycle of a slot
    logic [7:0] step; // increase for this slot
    logic [8:0] upSum; // wide to catch overflow

    assign slotTick = (slotCount == 32'(SLOT_LEN - 1));
    assign step = fpr_step_size(rif.rate);
    assign upSum = {1'b0, duty} + {1'b0, step};

    // next-state: free-running slot timer, step clamped at target
    always_comb
    begin
        next_slotCount = slotTick ? 32'h0000_0000 : slotCount + 32'h0000_0001;
        next_duty = duty;
        next_state = state;
        if (!rif.enable)
        begin
            // no stepping: follow target at once
            next_duty = rif.target;
            next_state = RAMP_HOLD;
        end
        else
        begin
            case (state)
                RAMP_HOLD:
                begin
                    if (duty != rif.target)
                    begin
                        next_state = RAMP_MOVE;
                    end
                end
                RAMP_MOVE:
                begin
                    if (duty == rif.target)
                    begin
                        next_state = RAMP_HOLD;
                    end
                    else if (slotTick)
                    begin
                        // one step per slot, never past target
                        if (rif.target > duty)
                        begin
                            next_duty = (upSum > {1'b0, rif.target}) ? rif.target : upSum[7:0];
                        end
                        else
                        begin
                            next_duty = ((duty - rif.target) < step) ? rif.target : duty - step;
                        end
                    end
                end
                default:
                begin
                    next_state = RAMP_HOLD;
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state <= RAMP_HOLD;
            slotCount <= 32'h0000_0000;
            duty <= 8'h00;
        end
        else
        begin
            state <= next_state;
            slotCount <= next_slotCount;
            duty <= next_duty;
        end
    end

    assign rif.duty = duty;
    assign rif.busy = (state == RAMP_MOVE);

    // duty moves only on a slot boundary while ramping
    a_ramp_slot_only: assert property (@(posedge clock) disable iff (!rst_b)
        rif.enable && $past(rif.enable) && !$past(slotTick) && $past(rst_b) |-> duty == $past(duty))
        else $error("ramp moved outside a slot boundary");
    // upward step equals the rate's size unless clamped
    a_ramp_step_size: assert property (@(posedge clock) disable iff (!rst_b)
        rif.enable && state == RAMP_MOVE && slotTick && rif.target > upSum ##1 rif.enable
        |-> duty == $past(upSum[7:0]))
        else $error("ramp step size wrong");
    // disabled means direct follow
    a_ramp_direct: assert property (@(posedge clock) disable iff (!rst_b)
        !rif.enable |=> duty == $past(rif.target))
        else $error("duty not applied directly");
    // slot timer restarts at zero after the last cycle of a slot
    a_slot_period: assert property (@(posedge clock) disable iff (!rst_b)
        slotTick |=> slotCount == 32'h0000_0000)
        else $error("slot timer wrong");
    c_ramp_up: cover property (@(posedge clock) disable iff (!rst_b)
        rif.enable && slotTick && state == RAMP_MOVE && rif.target > duty);
    c_ramp_down: cover property (@(posedge clock) disable iff (!rst_b)
        rif.enable && slotTick && state == RAMP_MOVE && rif.target < duty);
endmodule : fpr_ramp

/* hw/fpr_ramp_if.sv */
`timescale 1ns/1ps
// link between the register block and the output 1 ramp engine
interface fpr_ramp_if;
    logic enable; // ramping on
    logic [2:0] rate; // rate code
    logic [7:0] target; // newly computed duty
    logic [7:0] duty; // applied duty
    logic busy; // duty not yet at target
    modport ctrl (output enable, output rate, output target, input duty, input busy);
    modport engine (input enable, input rate, input target, output duty, output busy);
endinterface : fpr_ramp_if

/* hw/fpr_top.sv */
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module fpr_top
    import fpr_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic autoMode,
    input wire logic [2:0] belowThresh,
    input wire logic [7:0] calcDuty1,
    input wire logic [7:0] calcDuty2,
    input wire logic [7:0] calcDuty3,
    input wire logic [7:0] minDuty1,
    input wire logic [7:0] minDuty2,
    input wire logic [7:0] minDuty3,
    output logic [7:0] fanDrive1,
    output logic [7:0] fanDrive2,
    output logic [7:0] fanDrive3,
    output logic [2:0] tachSyncEn
);
    // register and bus answer state
    logic [7:0] cfg, next_cfg; // acoustic ramp config
    logic [31:0] next_prdata; // read data
    logic next_pready; // one wait state
    logic next_pslverr; // unmapped address
    // fan side state
    logic [7:0] target1; // output 1 target before ramp
    logic [7:0] next_fanDrive2, next_fanDrive3; // directly driven outputs
    logic [2:0] next_tachSyncEn; // tach inputs tied to output 3
    // decode of the live transfer
    logic access; // access phase, answer given
    logic hitCfg, hitStat; // address decode

    // carrier to the output 1 ramp engine; enable, rate and target go out
    fpr_ramp_if rif();

    // pick target: below threshold gives 0% or minimum in auto mode
    // the auto flag is an argument so every caller sees it move; a function
    // reading module state behind a continuous assign would miss that change
    function automatic logic [7:0] below_pick(input logic autoOn, input logic below, input logic useMin,
                                               input logic [7:0] minDuty, input logic [7:0] calc);
        if (autoOn && below)
        begin
            below_pick = useMin ? minDuty : 8'h00;
        end
        else
        begin
            below_pick = calc;
        end
    endfunction : below_pick

    // the answer is taken at the edge where the master sees pready
    assign access = psel && penable && pready;
    assign hitCfg = (paddr == CFG_OFFSET);
    assign hitStat = (paddr == STATUS_OFFSET);
    // output 1 target feeds the ramp, so below-threshold levels ramp too
    assign target1 = below_pick(autoMode, belowThresh[0], cfg[MIN_OUT1_BIT], minDuty1, calcDuty1);

    // register bus: write lands at the edge where pready is high
    // pready comes one cycle into access so read data leaves a flop
    always_comb
    begin
        next_cfg = cfg;
        next_pready = psel && penable && !pready;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        // status writes fall through and are dropped without error
        if (access && pwrite && hitCfg)
        begin
            next_cfg = pwdata[7:0];
        end
        if (psel && penable && !pready)
        begin
            // answer prepared during the wait cycle
            next_pslverr = !(hitCfg || hitStat);
            if (!pwrite && hitCfg)
            begin
                next_prdata = {24'h00_0000, cfg};
            end
            else if (!pwrite && hitStat)
            begin
                next_prdata = {23'h00_0000, rif.busy, rif.duty};
            end
        end
    end

    // fan outputs and tach sync selection
    // outputs 2 and 3 have no ramp here; they follow one cycle late
    always_comb
    begin
        next_fanDrive2 = below_pick(autoMode, belowThresh[1], cfg[MIN_OUT2_BIT], minDuty2, calcDuty2);
        next_fanDrive3 = below_pick(autoMode, belowThresh[2], cfg[MIN_OUT3_BIT], minDuty3, calcDuty3);
        // inputs 3 and 4 always follow output 3; input 2 only with sync set
        next_tachSyncEn = {2'b11, cfg[TACH_SYNC_BIT]};
    end

    // bus registers only
    // one wait state is the price of a registered answer
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            cfg <= CFG_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            cfg <= next_cfg;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // fan output registers only
    // reset leaves inputs 3 and 4 synced and input 2 free, as with bit 4 clear
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            fanDrive2 <= 8'h00;
            fanDrive3 <= 8'h00;
            tachSyncEn <= 3'h6;
        end
        else
        begin
            fanDrive2 <= next_fanDrive2;
            fanDrive3 <= next_fanDrive3;
            tachSyncEn <= next_tachSyncEn;
        end
    end

    // ramp engine for output 1; its duty is already a flop
    // rate and enable go straight from config, so a new rate acts at the next slot
    assign rif.enable = cfg[RAMP_EN_BIT];
    assign rif.rate = cfg[RATE_LSB +: 3];
    assign rif.target = target1;
    assign fanDrive1 = rif.duty;

    fpr_ramp #(.SLOT_LEN(SLOT_LEN)) u_ramp (
        .clock(clock),
        .rst_b(rst_b),
        .rif(rif.engine)
    );

    // config reads zero right after reset
    a_cfg_reset: assert property (@(posedge clock) !rst_b |=> cfg == 8'h00)
        else $error("config not zero after reset");
    // ramp enable follows bit 3
    a_ramp_enable: assert property (@(posedge clock) disable iff (!rst_b)
        !cfg[RAMP_EN_BIT] |=> fanDrive1 == $past(target1))
        else $error("output 1 stepped while ramping off");
    // sync bit set ties input 2
    a_tach_sync_on: assert property (@(posedge clock) disable iff (!rst_b)
        cfg[TACH_SYNC_BIT] |=> tachSyncEn == 3'h7)
        else $error("tach 2 not synced");
    // sync bit clear leaves input 2 free
    a_tach_sync_off: assert property (@(posedge clock) disable iff (!rst_b)
        !cfg[TACH_SYNC_BIT] |=> tachSyncEn == 3'h6)
        else $error("tach sync wrong with bit clear");
    // output 1 below threshold, ramp off
    a_min_out1: assert property (@(posedge clock) disable iff (!rst_b)
        autoMode && belowThresh[0] && !cfg[RAMP_EN_BIT]
        |=> fanDrive1 == ($past(cfg[MIN_OUT1_BIT]) ? $past(minDuty1) : 8'h00))
        else $error("output 1 below threshold wrong");
    // output 2 below threshold
    a_min_out2: assert property (@(posedge clock) disable iff (!rst_b)
        autoMode && belowThresh[1] |=> fanDrive2 == ($past(cfg[MIN_OUT2_BIT]) ? $past(minDuty2) : 8'h00))
        else $error("output 2 below threshold wrong");
    // output 2 outside the below-threshold case passes its computed duty
    a_pass_out2: assert property (@(posedge clock) disable iff (!rst_b)
        !(autoMode && belowThresh[1]) |=> fanDrive2 == $past(calcDuty2))
        else $error("output 2 duty not passed through");
    // output 3 below threshold
    a_min_out3: assert property (@(posedge clock) disable iff (!rst_b)
        autoMode && belowThresh[2] |=> fanDrive3 == ($past(cfg[MIN_OUT3_BIT]) ? $past(minDuty3) : 8'h00))
        else $error("output 3 below threshold wrong");
    // output 3 outside the below-threshold case passes its computed duty
    a_pass_out3: assert property (@(posedge clock) disable iff (!rst_b)
        !(autoMode && belowThresh[2]) |=> fanDrive3 == $past(calcDuty3))
        else $error("output 3 duty not passed through");
    // a write to config is visible the next cycle
    a_cfg_write: assert property (@(posedge clock) disable iff (!rst_b)
        access && pwrite && hitCfg |=> cfg == $past(pwdata[7:0]))
        else $error("config write lost");
    // config read returns the stored byte with upper bits zero
    a_cfg_readback: assert property (@(posedge clock) disable iff (!rst_b)
        psel && penable && !pready && !pwrite && hitCfg |=> prdata == {24'h00_0000, $past(cfg)})
        else $error("config read data wrong");
    // unmapped address answers with an error and zero data
    a_bad_addr: assert property (@(posedge clock) disable iff (!rst_b)
        psel && penable && !pready && !(hitCfg || hitStat) |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    // status is read-only: a write there leaves config alone
    a_status_readonly: assert property (@(posedge clock) disable iff (!rst_b)
        access && pwrite && hitStat |=> cfg == $past(cfg))
        else $error("status write changed config");
    // ready stands one cycle per transfer
    a_pready_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        pready |=> !pready)
        else $error("ready held too long");

    // main scenarios
    c_cfg_write: cover property (@(posedge clock) disable iff (!rst_b) access && pwrite && hitCfg);
    c_below_min: cover property (@(posedge clock) disable iff (!rst_b)
        autoMode && belowThresh[0] && cfg[MIN_OUT1_BIT]);
    c_bad_addr: cover property (@(posedge clock) disable iff (!rst_b) pready && pslverr);
endmodule : fpr_top

/* verif/fpr_fan_model.sv */
`timescale 1ns/1ps
// behavioural cooling fans on the three drive outputs
module fpr_fan_model
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] duty1,
    input wire logic [7:0] duty2,
    input wire logic [7:0] duty3,
    output logic [2:0] spinning
);
    // a fan only turns while its duty is nonzero; one cycle of inertia
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            spinning <= 3'h0;
        else
            spinning <= {duty3 != 8'h00, duty2 != 8'h00, duty1 != 8'h00};
    end
endmodule : fpr_fan_model

/* verif/tb_fan_pwm_acoustic_ramp_config.sv */
`timescale 1ns/1ps
// self-checking bench for the acoustic ramp register block
module tb_fan_pwm_acoustic_ramp_config
    import fpr_pkg::*;
;
    // short slot keeps the ramp run brief
    localparam int SLOT = 8;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic autoMode = 1'b0;
    logic [2:0] belowThresh = 3'h0;
    logic [7:0] calcDuty1 = 8'h30, calcDuty2 = 8'h40, calcDuty3 = 8'h50;
    logic [7:0] minDuty1 = 8'h10, minDuty2 = 8'h11, minDuty3 = 8'h22;
    logic [7:0] fanDrive1, fanDrive2, fanDrive3;
    logic [2:0] tachSyncEn, fanSpin;
    int failCount = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    // ordinary cases: config, auto, below, expected drives and sync
    typedef struct {logic [7:0] cfg; logic auto; logic [2:0] below;
        logic [7:0] d1, d2, d3; logic [2:0] sync;} fpr_row_type;
    fpr_row_type rows [6] = '{
        '{8'h00, 1'b0, 3'h7, 8'h30, 8'h40, 8'h50, 3'h6},
        '{8'h10, 1'b1, 3'h0, 8'h30, 8'h40, 8'h50, 3'h7},
        '{8'h00, 1'b1, 3'h7, 8'h00, 8'h00, 8'h00, 3'h6},
        '{8'hE0, 1'b1, 3'h7, 8'h10, 8'h11, 8'h22, 3'h6},
        '{8'h60, 1'b1, 3'h5, 8'h10, 8'h40, 8'h00, 3'h6},
        '{8'hA0, 1'b1, 3'h2, 8'h30, 8'h00, 8'h50, 3'h6}};
    logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};

    fpr_top #(.SLOT_LEN(SLOT)) dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .autoMode(autoMode), .belowThresh(belowThresh), .calcDuty1(calcDuty1),
        .calcDuty2(calcDuty2), .calcDuty3(calcDuty3), .minDuty1(minDuty1), .minDuty2(minDuty2),
        .minDuty3(minDuty3), .fanDrive1(fanDrive1), .fanDrive2(fanDrive2), .fanDrive3(fanDrive3),
        .tachSyncEn(tachSyncEn));
    fpr_fan_model fans (.clock(clock), .rst_b(rst_b), .duty1(fanDrive1), .duty2(fanDrive2),
        .duty3(fanDrive3), .spinning(fanSpin));

    // 5 ns period clock
    initial
    begin
        forever #2.5 clock = ~clock;
    end

    // cycle ceiling so a stuck handshake cannot hang the run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failCount++;
            complete_run();
        end
    end

    // value comparison with mismatch report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; called just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // wait states are the slave's choice; the global ceiling bounds this
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps a following call from re-raising psel in the same step
        @(posedge clock);
    endtask : apb

    // edges until fanDrive1 moves, capped at 40
    task automatic wait_change(output int cnt);
        logic [7:0] prev;
        prev = fanDrive1;
        cnt = 0;
        do
        begin
            @(posedge clock);
            cnt++;
        end
        while (fanDrive1 === prev && cnt < 40);
    endtask : wait_change

    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        chk("sync after reset", 3'h6, tachSyncEn);
        apb(1'b0, CFG_OFFSET, 32'h0);
        chk("config reset", {24'h0, CFG_RESET}, rd);
        // table of below-threshold and sync cases, ramp off
        foreach (rows[i])
        begin
            autoMode <= rows[i].auto;
            belowThresh <= rows[i].below;
            apb(1'b1, CFG_OFFSET, {24'h0, rows[i].cfg});
            repeat (3) @(posedge clock);
            chk("drive1", rows[i].d1, fanDrive1);
            chk("drive2", rows[i].d2, fanDrive2);
            chk("drive3", rows[i].d3, fanDrive3);
            chk("sync", rows[i].sync, tachSyncEn);
            chk("spin", {rows[i].d3 != 8'h00, rows[i].d2 != 8'h00, rows[i].d1 != 8'h00}, fanSpin);
        end
        // unmapped access refused, status write dropped, register left alone
        apb(1'b1, 8'h08, 32'hFF);
        chk("unmapped error", 1'b1, err);
        apb(1'b1, STATUS_OFFSET, 32'hFF);
        chk("status write error", 1'b0, err);
        apb(1'b0, CFG_OFFSET, 32'h0);
        chk("config readback", 32'hA0, rd);
        autoMode <= 1'b0;
        // every rate code: step size, slot spacing; clamp at target 0x50 only reached at code 111
        for (int c = 0; c < 8; c++)
        begin
            calcDuty1 <= 8'h00;
            apb(1'b1, CFG_OFFSET, 32'h0);
            repeat (3) @(posedge clock);
            chk("direct duty", 8'h00, fanDrive1);
            apb(1'b1, CFG_OFFSET, {28'h0, 1'b1, c[2:0]});
            calcDuty1 <= 8'h50;
            wait_change(n);
            chk("first step", steps[c], fanDrive1);
            wait_change(n);
            chk("slot spacing", SLOT, n);
            chk("second step", (2 * steps[c] > 8'h50) ? 8'h50 : 2 * steps[c], fanDrive1);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            chk("busy", (2 * steps[c] < 8'h50) ? 1'b1 : 1'b0, rd[STAT_BUSY_BIT]);
            chk("status duty", (2 * steps[c] > 8'h50) ? 8'h50 : 2 * steps[c], rd[7:0]);
        end
        // downward move at code 111: one step of 48, then clamp at target
        calcDuty1 <= 8'h10;
        wait_change(n);
        chk("down step", 8'h20, fanDrive1);
        wait_change(n);
        chk("down clamp", 8'h10, fanDrive1);
        // ramp enable cleared: new duty lands at once
        apb(1'b1, CFG_OFFSET, 32'h0);
        calcDuty1 <= 8'hC0;
        repeat (3) @(posedge clock);
        chk("ramp off jump", 8'hC0, fanDrive1);
        // reset in mid-run with every config bit set
        apb(1'b1, CFG_OFFSET, 32'hFF);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        chk("drive1 after reset", 8'h00, fanDrive1);
        chk("drive2 after reset", 8'h00, fanDrive2);
        chk("sync after second reset", 3'h6, tachSyncEn);
        apb(1'b0, CFG_OFFSET, 32'h0);
        chk("config after second reset", {24'h0, CFG_RESET}, rd);
        complete_run();
    end
endmodule : tb_fan_pwm_acoustic_ramp_config
